// file: rtl/sld_frame_timer.sv
`timescale 1ns/1ps
`include "sld_params.svh"
module sld_frame_timer
  import sld_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       low_tick,
  input  wire logic       hs_tick,
  input  wire logic       hs_select,
  input  wire logic [2:0] prediv_code,
  input  wire logic [2:0] duty,
  input  wire logic [1:0] frame_code,
  input  wire logic [2:0] ncom_m1,
  output logic      [2:0] slot,
  output logic            polarity,
  output logic            frame_start
);

  logic [9:0]  pre_cnt_r;
  logic        pre_tick_r;
  logic [10:0] slot_cnt_r;
  logic [2:0]  slot_r;
  logic        pol_r;
  logic        frame_r;

  // ----------------------------------------------------------------
  // drive clock selection and predivider
  // ----------------------------------------------------------------
  wire [2:0]  pre_code  = (prediv_code > `SLD_PREDIV_MAX_CODE) ? `SLD_PREDIV_MAX_CODE : prediv_code;
  wire [9:0]  pre_ratio = `SLD_PREDIV_MIN << pre_code;
  wire        pre_wrap  = hs_tick && (pre_cnt_r == pre_ratio - 10'h001);
  wire        tick      = hs_select ? pre_tick_r : low_tick;

  // ----------------------------------------------------------------
  // slot length: frame length shared out over the active commons
  // ----------------------------------------------------------------
  wire [10:0] div_norm = (frame_code == 2'h0) ? `SLD_FRAME_DIV0 :
                         (frame_code == 2'h1) ? `SLD_FRAME_DIV1 :
                         (frame_code == 2'h2) ? `SLD_FRAME_DIV2 : `SLD_FRAME_DIV3;
  wire [10:0] div_third = (frame_code == 2'h0) ? 11'(`SLD_THIRD_DIV0 / 3) :
                          (frame_code == 2'h1) ? 11'(`SLD_THIRD_DIV1 / 3) :
                          (frame_code == 2'h2) ? 11'(`SLD_THIRD_DIV2 / 3) : 11'(`SLD_THIRD_DIV3 / 3);
  wire [10:0] slot_len = (duty == SLD_DUTY_THIRD)   ? div_third :
                         (duty == SLD_DUTY_EIGHTH)  ? (div_norm >> 3) :
                         (duty == SLD_DUTY_QUARTER) ? (div_norm >> 2) :
                         (duty == SLD_DUTY_HALF)    ? (div_norm >> 1) : div_norm;
  wire        slot_end  = tick && (slot_cnt_r >= slot_len - 11'h001);
  wire        frame_end = slot_end && (slot_r >= ncom_m1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_r  <= 10'h000;
      pre_tick_r <= 1'b0;
    end else begin
      pre_cnt_r  <= (!hs_select || pre_wrap) ? 10'h000 : (hs_tick ? pre_cnt_r + 10'h001 : pre_cnt_r);
      pre_tick_r <= hs_select && pre_wrap;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt_r <= 11'h000;
      slot_r     <= 3'h0;
      pol_r      <= 1'b0;
      frame_r    <= 1'b0;
    end else if (!run) begin
      slot_cnt_r <= 11'h000;
      slot_r     <= 3'h0;
      pol_r      <= 1'b0;
      frame_r    <= 1'b0;
    end else begin
      slot_cnt_r <= slot_end ? 11'h000 : (tick ? slot_cnt_r + 11'h001 : slot_cnt_r);
      slot_r     <= frame_end ? 3'h0 : (slot_end ? slot_r + 3'h1 : slot_r);
      pol_r      <= frame_end ? ~pol_r : pol_r;
      frame_r    <= frame_end;
    end
  end

  assign slot        = slot_r;
  assign polarity    = pol_r;
  assign frame_start = frame_r;

endmodule : sld_frame_timer

// file: rtl/sld_lcd_driver.sv
`timescale 1ns/1ps
`include "sld_params.svh"
module sld_lcd_driver
  import sld_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [14:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        low_freq_oscillator_tick,
  input  wire logic        high_speed_clock_tick,
  input  wire logic        sleep_active,
  output sld_pins_type     pins,
  output logic      [3:0]  contrast_level,
  output logic             frame_pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sld_bus_state_type bus_state_r;
  sld_bus_state_type bus_state_nxt;
  logic [7:0]   display_control_r;
  logic [7:0]   contrast_adjust_r;
  logic [7:0]   panel_clock_control_r;
  logic [7:0]   panel_clock_source_r;
  logic [7:0]   mem_r [0:`SLD_MEM_BYTES-1];
  logic [31:0]  rdata_r;
  logic         wait_r;
  sld_pins_type pins_r;
  logic         frame_pulse_r;
  logic [2:0]   slot;
  logic         polarity;
  logic         frame_start;
  sld_pins_type pins_nxt;
  logic [1:0]   com_lvl [0:7];
  logic [1:0]   seg_lvl [0:19];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req       = avs_read || avs_write;
  // a request completes at the edge where waitrequest is seen low
  wire accept    = req && !wait_r;
  wire wr_go     = accept && avs_write && avs_byteenable[0];
  wire [7:0] wb  = avs_writedata[7:0];
  wire hit_dc    = (avs_address == `SLD_IDX_DISPLAY_CONTROL);
  wire hit_ca    = (avs_address == `SLD_IDX_CONTRAST_ADJUST);
  wire hit_cc    = (avs_address == `SLD_IDX_PANEL_CLOCK_CONTROL);
  wire hit_src   = (avs_address == `SLD_IDX_PANEL_CLOCK_SOURCE);
  wire hit_st    = (avs_address == `SLD_IDX_FRAME_STATUS);
  wire hit_mem   = (avs_address >= `SLD_IDX_MEM_FIRST) && (avs_address <= `SLD_IDX_MEM_LAST);
  wire [14:0] mem_off = avs_address - `SLD_IDX_MEM_FIRST;
  wire [4:0]  mem_idx = mem_off[4:0];

  always_comb begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      SLD_BUS_IDLE: begin
        if (req) begin
          bus_state_nxt = SLD_BUS_ACK;
        end
      end
      SLD_BUS_ACK: begin
        bus_state_nxt = SLD_BUS_IDLE;
      end
      default: begin
        bus_state_nxt = SLD_BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  wire [2:0]  duty      = panel_clock_control_r[2:0];
  wire [1:0]  frame_code = panel_clock_control_r[`SLD_CC_FRAME_MSB:`SLD_CC_FRAME_LSB];
  wire        hs_select = panel_clock_source_r[`SLD_SRC_HS];
  wire [2:0]  prediv_code = panel_clock_source_r[3:1];
  wire        seg_asc   = display_control_r[`SLD_DC_SEG_ORDER];
  wire        com_asc   = display_control_r[`SLD_DC_COM_ORDER];
  wire        area1     = display_control_r[`SLD_DC_AREA];
  wire        normal_px = display_control_r[`SLD_DC_REVERSE];
  wire        duty_ok   = (duty <= SLD_DUTY_EIGHTH);
  wire        eighth    = (duty == SLD_DUTY_EIGHTH);
  wire [2:0]  ncom_m1   = (duty == SLD_DUTY_EIGHTH)  ? 3'h7 :
                          (duty == SLD_DUTY_QUARTER) ? 3'h3 :
                          (duty == SLD_DUTY_THIRD)   ? 3'h2 :
                          (duty == SLD_DUTY_HALF)    ? 3'h1 : 3'h0;
  wire [1:0]  eff_state = sleep_active ? SLD_DISP_OFF : display_control_r[1:0];
  wire        st_off    = (eff_state == SLD_DISP_OFF) || !duty_ok;
  wire        st_all_on = (eff_state == SLD_DISP_ALL_ON);
  wire        st_all_off = (eff_state == SLD_DISP_ALL_OFF);
  // caller supplies a running drive clock before normal display
  wire        run       = !st_off;

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  sld_frame_timer u_timer (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .run         (run),
    .low_tick    (low_freq_oscillator_tick),
    .hs_tick     (high_speed_clock_tick),
    .hs_select   (hs_select),
    .prediv_code (prediv_code),
    .duty        (duty),
    .frame_code  (frame_code),
    .ncom_m1     (ncom_m1),
    .slot        (slot),
    .polarity    (polarity),
    .frame_start (frame_start)
  );

  // ----------------------------------------------------------------
  // memory mapping
  // ----------------------------------------------------------------
  // common bit order
  wire [2:0]  com_bit  = com_asc ? slot : (ncom_m1 - slot);
  wire [2:0]  pix_bit  = (area1 && !eighth) ? (com_bit + 3'h4) : com_bit;
  wire [4:0]  nseg_m1  = eighth ? 5'h0F : 5'h13;

  wire [1:0]  lv_com_sel   = polarity ? SLD_LVL_VC3 : SLD_LVL_VSS;
  wire [1:0]  lv_com_unsel = polarity ? SLD_LVL_VC1 : SLD_LVL_VC2;
  wire [1:0]  lv_seg_on    = polarity ? SLD_LVL_VSS : SLD_LVL_VC3;
  wire [1:0]  lv_seg_off   = polarity ? SLD_LVL_VC2 : SLD_LVL_VC1;

  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_seg
      wire [4:0] addr  = seg_asc ? 5'(gi) : (nseg_m1 - 5'(gi));
      wire       pix   = mem_r[addr][pix_bit];
      wire       shown = st_all_on ? 1'b1 : pix;
      wire       lit   = shown ^ !normal_px;
      assign seg_lvl[gi] = st_off     ? SLD_LVL_VSS :
                           st_all_off ? lv_com_sel :
                           (lit ? lv_seg_on : lv_seg_off);
    end
    for (gi = 0; gi < 8; gi++) begin : g_com
      wire active = (3'(gi) <= ncom_m1);
      wire sel    = active && (st_all_off || (slot == 3'(gi)));
      assign com_lvl[gi] = st_off ? SLD_LVL_VSS : (sel ? lv_com_sel : lv_com_unsel);
    end
    for (gi = 0; gi < 16; gi++) begin : g_seg_pin
      assign pins_nxt.seg[gi] = seg_lvl[gi];
    end
    for (gi = 0; gi < 4; gi++) begin : g_shared
      assign pins_nxt.com[gi]    = com_lvl[gi];
      assign pins_nxt.shared[gi] = eighth ? com_lvl[gi+4] : seg_lvl[gi+16];
    end
  endgenerate

  assign pins_nxt.shared_is_com = eighth;
  assign pins_nxt.supply_on     = !st_off;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [7:0] status_byte = {3'h0, run, slot, polarity};
  wire [7:0] rd_byte = hit_dc  ? (display_control_r & `SLD_DC_MASK) :
                       hit_ca  ? (contrast_adjust_r & `SLD_CA_MASK) :
                       hit_cc  ? (panel_clock_control_r & `SLD_CC_MASK) :
                       hit_src ? (panel_clock_source_r & `SLD_SRC_MASK) :
                       hit_st  ? status_byte :
                       hit_mem ? mem_r[mem_idx] : 8'h00;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_r <= SLD_BUS_IDLE;
      wait_r      <= 1'b1;
      rdata_r     <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      wait_r      <= !(bus_state_r == SLD_BUS_IDLE && req);
      rdata_r     <= (bus_state_r == SLD_BUS_IDLE && avs_read) ? {24'h00_0000, rd_byte} : rdata_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      display_control_r <= `SLD_DC_RESET;
    end else if (wr_go && hit_dc) begin
      display_control_r <= wb & `SLD_DC_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      contrast_adjust_r <= `SLD_CA_RESET;
    end else if (wr_go && hit_ca) begin
      contrast_adjust_r <= wb & `SLD_CA_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_clock_control_r <= `SLD_CC_RESET;
      panel_clock_source_r  <= `SLD_SRC_RESET;
    end else begin
      if (wr_go && hit_cc) begin
        panel_clock_control_r <= wb & `SLD_CC_MASK;
      end
      if (wr_go && hit_src) begin
        panel_clock_source_r <= wb & `SLD_SRC_MASK;
      end
    end
  end

  // whole bytes stored, used or not
  generate
    for (gi = 0; gi < `SLD_MEM_BYTES; gi++) begin : g_mem
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_r[gi] <= 8'h00;
        end else if (wr_go && hit_mem && (mem_idx == 5'(gi))) begin
          mem_r[gi] <= wb;
        end
      end
    end
  endgenerate

  // pins are registered so the panel never sees decode glitches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_r        <= '0;
      frame_pulse_r <= 1'b0;
    end else begin
      pins_r        <= pins_nxt;
      frame_pulse_r <= frame_start;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pins            = pins_r;
  assign contrast_level  = contrast_adjust_r[3:0];
  assign frame_pulse     = frame_pulse_r;

endmodule : sld_lcd_driver

// file: rtl/sld_params.svh
// Operation
// - frame length is 256, 512, 680 or 1024 drive clocks by divider code
// - under 1/3 duty frame lengths become 252, 504, 681 and 1008
// - duty code 4=1/8, 3=1/4, 2=1/3, 1=1/2, 0=static; 5-7 reserved; reset 4
// - 1/8 drives com0-7 seg0-15; otherwise shared pins become seg16-19
// - every duty uses one-third bias with three drive potentials
// - twenty bytes of display memory at indices 0x53c0 to 0x53d3
// - memory bit one lights its pixel, zero clears it; bits read back
// - unmapped memory bits act as plain read/write storage
// - reduced duties show low nibble for area 0, high nibble for area 1
// - segment order bit one ascending addresses, zero descending
// - common order bit one ascending bits, zero descending
// - display state 0 off, 1 normal, 2 all on, 3 all off
// - display off stops drive supply, all potentials at ground
// - all on/off override waveform only; commons dynamic on, static off
// - display state resets off; sleep forces off and wake restores it
// - four-bit contrast code, 0xf darkest, 0x0 lightest, reset 0x7
// - reverse bit zero inverts every pixel, memory untouched
// - inversion ignored for all off but applied for all on
// - high speed source is predivided by 1/32 to 1/512 first
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SLD_IDX_DISPLAY_CONTROL     15'h50A0
`define SLD_IDX_CONTRAST_ADJUST     15'h50A1
`define SLD_IDX_PANEL_CLOCK_CONTROL 15'h50A2
`define SLD_IDX_PANEL_CLOCK_SOURCE  15'h50A4
`define SLD_IDX_FRAME_STATUS        15'h50A7
`define SLD_IDX_MEM_FIRST           15'h53C0
`define SLD_IDX_MEM_LAST            15'h53D3
`define SLD_MEM_BYTES               20

// ----------------------------------------------------------------
// field positions, masks and reset values
// ----------------------------------------------------------------
`define SLD_DC_SEG_ORDER   7
`define SLD_DC_COM_ORDER   6
`define SLD_DC_AREA        5
`define SLD_DC_REVERSE     4
`define SLD_CC_FRAME_MSB   7
`define SLD_CC_FRAME_LSB   6
`define SLD_SRC_HS         0
`define SLD_DC_MASK        8'hF3
`define SLD_CA_MASK        8'h0F
`define SLD_CC_MASK        8'hC7
`define SLD_SRC_MASK       8'h0F
`define SLD_DC_RESET       8'hD0
`define SLD_CA_RESET       8'h07
`define SLD_CC_RESET       8'h44
`define SLD_SRC_RESET      8'h00

// ----------------------------------------------------------------
// timing counts in drive clock periods; predivider ratio in high speed ticks
// ----------------------------------------------------------------
`define SLD_FRAME_DIV0     11'h100
`define SLD_FRAME_DIV1     11'h200
`define SLD_FRAME_DIV2     11'h2A8
`define SLD_FRAME_DIV3     11'h400
`define SLD_THIRD_DIV0     11'h0FC
`define SLD_THIRD_DIV1     11'h1F8
`define SLD_THIRD_DIV2     11'h2A9
`define SLD_THIRD_DIV3     11'h3F0
`define SLD_PREDIV_MIN     10'h020
`define SLD_PREDIV_MAX_CODE 3'h4

`endif

// file: rtl/sld_pkg.sv
package sld_pkg;

  typedef enum logic [2:0] {
    SLD_DUTY_STATIC  = 3'h0,
    SLD_DUTY_HALF    = 3'h1,
    SLD_DUTY_THIRD   = 3'h2,
    SLD_DUTY_QUARTER = 3'h3,
    SLD_DUTY_EIGHTH  = 3'h4
  } sld_duty_type;

  typedef enum logic [1:0] {
    SLD_DISP_OFF     = 2'h0,
    SLD_DISP_NORMAL  = 2'h1,
    SLD_DISP_ALL_ON  = 2'h2,
    SLD_DISP_ALL_OFF = 2'h3
  } sld_disp_type;

  typedef enum logic [1:0] {
    SLD_LVL_VSS = 2'h0,
    SLD_LVL_VC1 = 2'h1,
    SLD_LVL_VC2 = 2'h2,
    SLD_LVL_VC3 = 2'h3
  } sld_level_type;

  typedef enum logic [1:0] {
    SLD_BUS_IDLE = 2'b01,
    SLD_BUS_ACK  = 2'b10
  } sld_bus_state_type;

  typedef struct packed {
    logic                 supply_on;
    logic                 shared_is_com;
    logic [3:0][1:0]      com;
    logic [3:0][1:0]      shared;
    logic [15:0][1:0]     seg;
  } sld_pins_type;

endpackage : sld_pkg

// file: tb/sld_lcd_checker.sv
`timescale 1ns/1ps
`include "sld_params.svh"
module sld_lcd_checker
  import sld_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic  [14:0] avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic  [31:0] avs_writedata,
  input wire logic  [3:0]  avs_byteenable,
  input wire logic  [31:0] avs_readdata,
  input wire logic         avs_waitrequest,
  input wire logic         low_freq_oscillator_tick,
  input wire logic         high_speed_clock_tick,
  input wire logic         sleep_active,
  input wire sld_pins_type pins,
  input wire logic  [3:0]  contrast_level,
  input wire logic         frame_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic req;
  logic wr_ca;
  assign req   = avs_read | avs_write;
  assign wr_ca = avs_write & ~avs_waitrequest & avs_byteenable[0] & (avs_address == `SLD_IDX_CONTRAST_ADJUST);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  chk_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_idle_wait: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_hole_zero: assert property (avs_read && !avs_waitrequest && avs_address == 15'h50A3 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_contrast_write: assert property (wr_ca |=> contrast_level == $past(avs_writedata[3:0]))
    else $error("contrast not written");
  chk_contrast_hold: assert property (!$stable(contrast_level) |-> $past(wr_ca))
    else $error("contrast changed alone");

  // ----------------------------------------------------------------
  // display outputs
  // ----------------------------------------------------------------
  chk_pulse_gap: assert property (frame_pulse |=> !frame_pulse [*8])
    else $error("frame pulses too close");
  chk_sleep_pins: assert property (sleep_active [*3] |=> !pins.supply_on && pins.seg == '0)
    else $error("pins driven in sleep");
  chk_sleep_quiet: assert property (sleep_active [*4] |-> !frame_pulse)
    else $error("frame during sleep");
  chk_off_vss: assert property (!pins.supply_on |-> pins.com == '0 && pins.shared == '0 && pins.seg == '0)
    else $error("potential above ground while off");

  cov_contrast: cover property (wr_ca);
  cov_frame: cover property (frame_pulse);
  cov_supply_drop: cover property (pins.supply_on ##1 !pins.supply_on);
endmodule : sld_lcd_checker

bind sld_lcd_driver sld_lcd_checker u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .low_freq_oscillator_tick(low_freq_oscillator_tick), .high_speed_clock_tick(high_speed_clock_tick),
  .sleep_active(sleep_active), .pins(pins), .contrast_level(contrast_level), .frame_pulse(frame_pulse)
);

// file: tb/sld_panel_model.sv
`timescale 1ns/1ps
module sld_panel_model
  import sld_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire sld_pins_type pins,
  input  wire logic         clear,
  output logic [7:0][19:0]  lit
);
  logic [7:0][1:0]  com_lv;
  logic [19:0][1:0] seg_lv;
  // ----------------------------------------------------------------
  // pixel response
  // ----------------------------------------------------------------
  // shared pins role
  assign com_lv = {pins.shared, pins.com};
  assign seg_lv = {pins.shared, pins.seg};
  // full swing only
  // a pixel turns only under the full outer swing; partial bias never lights it
  always @(posedge sys_clk) begin
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 20; s++) begin
        if (clear) begin
          lit[c][s] <= 1'b0;
        end else if (pins.supply_on && (c < 4 || pins.shared_is_com) && (s < 16 || !pins.shared_is_com)
                     && ({com_lv[c], seg_lv[s]} inside {4'h3, 4'hC})) begin
          lit[c][s] <= 1'b1;
        end
      end
    end
  end
endmodule : sld_panel_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sld_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [14:0]      avs_address = 15'h0000;
  logic [31:0]      avs_writedata = 32'h0;
  logic [3:0]       avs_byteenable = 4'hF;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             lf_tick = 1'b0;
  logic             hs_tick = 1'b0;
  logic             sleep_active = 1'b0;
  logic             clear = 1'b1;
  sld_pins_type     pins;
  logic [63:0]      pins_w;
  logic [3:0]       contrast_level;
  logic             frame_pulse;
  logic [7:0][19:0] lit;
  logic [7:0]       mem [20];
  logic [7:0]       q;
  int               bad_count = 0;
  int               total_checks = 0;
  int               n;
  logic [14:0]      regs [3] = '{15'h50A0, 15'h50A1, 15'h50A2};
  logic [7:0]       masks [3] = '{8'hF3, 8'h0F, 8'hC7};
  logic [7:0]       dcs [8] = '{8'hD1, 8'hD2, 8'hD3, 8'hC1, 8'hC2, 8'hC3, 8'h51, 8'h91};
  int               divs [8] = '{256, 512, 680, 1024, 252, 504, 681, 1008};

  assign pins_w = 64'(pins);
  always #12.5 sys_clk = ~sys_clk;
  // drive clock runs from the start
  always @(posedge sys_clk) begin
    lf_tick <= ~lf_tick;
    hs_tick <= ~hs_tick;
  end

  sld_lcd_driver dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .low_freq_oscillator_tick(lf_tick),
    .high_speed_clock_tick(hs_tick), .sleep_active(sleep_active), .pins(pins),
    .contrast_level(contrast_level), .frame_pulse(frame_pulse)
  );
  sld_panel_model panel (.sys_clk(sys_clk), .pins(pins), .clear(clear), .lit(lit));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_lit(input logic [7:0][19:0] got, input logic [7:0][19:0] exp, input logic [7:0] dc);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t pixels dc %h got %h exp %h", $time, dc, got, exp);
    end
  endtask : cmp_lit

  task automatic bus(input logic w, input logic [14:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address    <= a;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= ~w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 50) cmp_val(64'h1, 64'h0, "bus timeout");
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic chk_rd(input logic [14:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    cmp_val({56'h0, q}, {56'h0, e}, "register read");
  endtask : chk_rd

  // bounded wait; n ends as the cycle count since the previous pulse minus one
  task automatic wait_frame();
    int k;
    k = 0;
    @(posedge sys_clk);
    while (frame_pulse !== 1'b1 && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
    n = k;
  endtask : wait_frame

  function automatic logic [7:0][19:0] expect_lit(input logic [7:0] dc, input logic [2:0] d);
    logic [7:0][19:0] e;
    int               nc, ns, b;
    logic             on;
    e = '0;
    nc = (d == 3'h4) ? 8 : (d == 3'h3) ? 4 : (d == 3'h2) ? 3 : (d == 3'h1) ? 2 : 1;
    ns = (d == 3'h4) ? 16 : 20;
    for (int c = 0; c < nc; c++) begin
      for (int s = 0; s < ns; s++) begin
        b = dc[6] ? c : nc - 1 - c;
        if (d != 3'h4 && dc[5]) b = b + 4;
        on = mem[dc[7] ? s : ns - 1 - s][b];
        if (dc[1:0] == 2'h2) on = 1'b1;
        if (dc[1:0] == 2'h3) on = 1'b0;
        else if (!dc[4]) on = ~on;
        e[c][s] = on;
      end
    end
    return e;
  endfunction : expect_lit

  // first frame after a change is mixed, so it is thrown away
  task automatic show(input logic [7:0] dc, input logic [2:0] d);
    wr(15'h50A2, {5'h00, d});
    wr(15'h50A0, dc);
    wait_frame();
    clear <= 1'b1;
    @(posedge sys_clk);
    clear <= 1'b0;
    wait_frame();
    cmp_lit(lit, expect_lit(dc, d), dc);
  endtask : show

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #2_400_000;
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    clear <= 1'b0;
    chk_rd(15'h50A0, 8'hD0);
    chk_rd(15'h50A1, 8'h07);
    chk_rd(15'h50A2, 8'h44);
    cmp_val({60'h0, contrast_level}, 64'h7, "contrast reset");
    for (int i = 0; i < 3; i++) begin
      wr(regs[i], 8'hFF);
      chk_rd(regs[i], masks[i]);
    end
    wr(15'h50A2, 8'h07);
    chk_rd(15'h50A2, 8'h07);
    for (int i = 0; i < 16; i++) begin
      wr(15'h50A1, 8'(i));
      #1;
      cmp_val({60'h0, contrast_level}, 64'(i), "contrast level");
    end
    bus(1'b1, 15'h50A1, 8'h05, 4'hE);
    chk_rd(15'h50A1, 8'h0F);
    wr(15'h50A3, 8'hAA);
    chk_rd(15'h50A3, 8'h00);
    chk_rd(15'h53D4, 8'h00);
    for (int i = 0; i < 20; i++) begin
      mem[i] = 8'(i * 37 + 5);
      wr(15'h53C0 + 15'(i), mem[i]);
    end
    for (int i = 0; i < 20; i++) chk_rd(15'h53C0 + 15'(i), mem[i]);
    $display("test registers done");
    for (int i = 0; i < 8; i++) show(dcs[i], 3'h4);
    for (int d = 0; d < 4; d++) begin
      show(8'hF1, 3'(d));
      show(8'h11, 3'(d));
    end
    $display("test mapping done");
    wr(15'h50A0, 8'hD0);
    repeat (3) @(posedge sys_clk);
    #1;
    cmp_val(pins_w, 64'h0, "pins while off");
    wr(15'h50A0, 8'hD1);
    wait_frame();
    sleep_active <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    cmp_val(pins_w, 64'h0, "pins in sleep");
    @(posedge sys_clk);
    sleep_active <= 1'b0;
    chk_rd(15'h50A0, 8'hD1);
    show(8'hD1, 3'h4);
    $display("test sleep done");
    for (int i = 0; i < 8; i++) begin
      wr(15'h50A2, {i[1:0], 3'h0, (i < 4) ? 3'h4 : 3'h2});
      wait_frame();
      wait_frame();
      cmp_val(64'(n + 1), 64'(2 * divs[i]), "frame length");
    end
    wr(15'h50A4, 8'h01);
    chk_rd(15'h50A4, 8'h01);
    wr(15'h50A2, 8'h04);
    wait_frame();
    wait_frame();
    cmp_val(64'(n + 1), 64'(2 * 32 * 256), "predivided frame");
    $display("test timing done");
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_rd(15'h50A0, 8'hD0);
    cmp_val(pins_w, 64'h0001_0000_0000_0000, "pins after reset");
    chk_rd(15'h50A7, 8'h00);
    $display("test rereset done");
    give_verdict();
  end
endmodule : tb
